// ---- pkg/tal_params.svh ----
// constants of the tape autolocator: offsets, fields, resets, timing
`ifndef TAL_PARAMS_SVH
`define TAL_PARAMS_SVH

// --------------------
// clock and timing
// --------------------
`define TAL_CLK_HZ 40000000
`define TAL_HOLD_MS 500
`define TAL_HOLD_CYCLES ((`TAL_CLK_HZ / 1000) * `TAL_HOLD_MS)
`define TAL_BLINK_MS 250
`define TAL_BLINK_CYCLES ((`TAL_CLK_HZ / 1000) * `TAL_BLINK_MS)
`define TAL_FLASH_MS 1000
`define TAL_FLASH_CYCLES ((`TAL_CLK_HZ / 1000) * `TAL_FLASH_MS)

// --------------------
// tape counter
// --------------------
`define TAL_CNT_W 14
`define TAL_CNT_MOD 10000
`define TAL_MIN_GAP 3
`define TAL_TRACKS 4

// --------------------
// apb register map
// --------------------
`define TAL_ADDR_W 8
`define TAL_CTRL_OFS 8'h00
`define TAL_STATUS_OFS 8'h04
`define TAL_COUNTER_OFS 8'h08
`define TAL_MARKER1_OFS 8'h0c
`define TAL_MARKER2_OFS 8'h10
`define TAL_CTRL_LOCK_BIT 0
`define TAL_CTRL_ERASE_BIT 1
`define TAL_CTRL_RESET 1'b0
`define TAL_STAT_PEND_BIT 4
`define TAL_STAT_V1_BIT 5
`define TAL_STAT_V2_BIT 6
`define TAL_STAT_REC_BIT 7

`endif

// ---- pkg/tal_pkg.sv ----
// types shared by the tape autolocator design files
package tal_pkg;

    // transport states
    typedef enum logic [3:0] {
        TAL_IDLE,
        TAL_PLAY,
        TAL_REC,
        TAL_WIND_HOME,
        TAL_LOCATE,
        TAL_LOOP_SEEK,
        TAL_LOOP_PLAY,
        TAL_LOOP_REW
    } tal_state_e;

    // front panel keys, high while pressed
    typedef struct packed {
        logic store_key;
        logic first_recall_key;
        logic second_recall_key;
        logic return_home_key;
        logic counter_clear_key;
        logic play_key;
        logic stop_key;
        logic record_key;
        logic loop_key;
    } tal_keys_s;

    // transport motor commands
    typedef struct packed {
        logic fast_forward;
        logic rewind;
        logic play;
        logic record;
    } tal_motor_s;

endpackage : tal_pkg

// ---- logic/tal_sync.sv ----
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps

module tal_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and synchronised levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : tal_sync

// ---- logic/tal_marker.sv ----
// one marker register with store, counter-clear recalculation and erase
`timescale 1ns/1ps

module tal_marker #(
    parameter int CW = 14,
    parameter int MOD = 10000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic erase,
    input wire logic store,
    input wire logic adjust,
    // data
    input wire logic [CW-1:0] value,
    input wire logic [CW-1:0] offset,
    output logic [CW-1:0] marker_q,
    output logic valid_q
);

    logic [CW:0] wrap_d;

    // marker minus offset, modulo the counter range
    always_comb
    begin
        if (marker_q >= offset)
            wrap_d = {1'b0, marker_q} - {1'b0, offset};
        else
            wrap_d = {1'b0, marker_q} + (CW+1)'(MOD) - {1'b0, offset};
    end

    // a new store simply replaces the old point
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            marker_q <= '0;
            valid_q <= 1'b0;
        end
        else if (erase)
        begin
            marker_q <= '0; // [RULE7]
            valid_q <= 1'b0;
        end
        else if (store)
        begin
            marker_q <= value; // [RULE1] [RULE2]
            valid_q <= 1'b1;
        end
        else if (adjust && valid_q)
        begin
            marker_q <= wrap_d[CW-1:0]; // [RULE4]
        end
    end

endmodule : tal_marker

// ---- logic/tal_top.sv ----
// tape autolocator: counter, two markers, locate, loop and track lamps
//
// Behaviour
// [RULE1] store key held plus recall key copies counter into that marker, lamp on
// [RULE2] every new store overwrites the previous marker value
// [RULE3] stores are ignored while locating to a marker or looping
// [RULE4] counter clear shifts both markers so they keep their tape spot
// [RULE5] recall held 0.5 s while stopped shows marker, no locate
// [RULE6] short recall tap fast winds toward that marker
// [RULE7] markers clear on cassette removal or power off
// [RULE8] return home key winds to counter zero and stops there
// [RULE9] counter clear during return home zeroes counter and stops
// [RULE10] locate needs distance of 3 or more, else marker lamp flashes
// [RULE11] play pressed while winding starts play on arrival
// [RULE12] loop start is the lower marker, loop end the higher
// [RULE13] loop request winds to loop start then plays
// [RULE14] at loop end rewind to start and play again, forever
// [RULE15] play with record held starts recording, armed lamps go steady
// [RULE16] stop ends recording, armed lamps blink again
// [RULE17] track at protected source is disarmed, lamp off
// [RULE18] four digit counter follows tape motion up and down
// [RULE19] markers under 3 apart: no loop, loop lamp off, both flash
// [RULE20] wind rewinds when counter above target, forward when below
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "tal_params.svh"

module tal_top #(
    parameter int HOLD_CYCLES = `TAL_HOLD_CYCLES,
    parameter int BLINK_CYCLES = `TAL_BLINK_CYCLES,
    parameter int FLASH_CYCLES = `TAL_FLASH_CYCLES,
    parameter int CW = `TAL_CNT_W,
    parameter int TRACKS = `TAL_TRACKS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TAL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // front panel and transport pins
    input wire tal_pkg::tal_keys_s panel_keys,
    input wire logic cassette_present,
    input wire logic tach_pulse,
    input wire logic tach_dir,
    input wire logic [TRACKS-1:0] track_source_live,
    // transport and display
    output tal_pkg::tal_motor_s motor,
    output logic [CW-1:0] display_value,
    output logic [1:0] marker_lamp,
    output logic loop_lamp,
    output logic [TRACKS-1:0] track_arm_lamp
);

    // --------------------
    // pin synchronisation
    // --------------------
    localparam int NK = $bits(tal_pkg::tal_keys_s);
    localparam int NS = NK + 3 + TRACKS;
    localparam logic [CW-1:0] CNT_MAX = CW'(`TAL_CNT_MOD - 1);
    localparam logic [CW-1:0] MIN_GAP = CW'(`TAL_MIN_GAP);

    logic [NS-1:0] sync_q;
    tal_pkg::tal_keys_s keys;
    tal_pkg::tal_keys_s keys_prev_q;
    tal_pkg::tal_keys_s key_rise;
    logic cass_q, tach_q, dir_q, cass_prev_q, tach_prev_q;
    logic [TRACKS-1:0] armed;

    tal_sync #(.W(NS)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({panel_keys, cassette_present, tach_pulse, tach_dir,
            track_source_live}),
        .q(sync_q)
    );

    // the lock bit masks every key, not the transport sensors
    logic lock_q;
    assign keys = lock_q ? '0 : sync_q[NS-1 -: NK];
    assign cass_q = sync_q[TRACKS+2];
    assign tach_q = sync_q[TRACKS+1];
    assign dir_q = sync_q[TRACKS];
    assign armed = sync_q[TRACKS-1:0]; // [RULE17]
    assign key_rise = keys & ~keys_prev_q;

    // edge history of the synchronised levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            keys_prev_q <= '0;
            cass_prev_q <= 1'b0;
            tach_prev_q <= 1'b0;
        end
        else
        begin
            keys_prev_q <= keys;
            cass_prev_q <= cass_q;
            tach_prev_q <= tach_q;
        end
    end

    // --------------------
    // helpers
    // --------------------
    function automatic logic [CW-1:0] absdiff(input logic [CW-1:0] a,
                                              input logic [CW-1:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    tal_pkg::tal_state_e state_q;
    logic [CW-1:0] counter_q, target_q, loop_lo_q, loop_hi_q;
    logic [CW-1:0] m1, m2, sel_marker;
    logic v1, v2, sel_valid;
    logic play_pend_q, erase_q;
    logic winding, looping, clear_ev, tach_ev, erase_ev;

    assign winding = state_q == tal_pkg::TAL_WIND_HOME ||
                     state_q == tal_pkg::TAL_LOCATE ||
                     state_q == tal_pkg::TAL_LOOP_SEEK ||
                     state_q == tal_pkg::TAL_LOOP_REW;
    assign looping = state_q == tal_pkg::TAL_LOOP_SEEK ||
                     state_q == tal_pkg::TAL_LOOP_PLAY ||
                     state_q == tal_pkg::TAL_LOOP_REW;
    assign clear_ev = key_rise.counter_clear_key;
    assign tach_ev = tach_q && !tach_prev_q;
    assign erase_ev = (cass_prev_q && !cass_q) || erase_q; // [RULE7]

    // --------------------
    // tape counter
    // --------------------
    // wraps at four digits so the markers stay comparable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            counter_q <= '0;
        else if (clear_ev)
            counter_q <= '0; // [RULE9]
        else if (tach_ev && dir_q)
            counter_q <= (counter_q == CNT_MAX) ? '0 : counter_q + 1'b1;
        else if (tach_ev)
            counter_q <= (counter_q == '0) ? CNT_MAX : counter_q - 1'b1;
    end // [RULE18]

    // --------------------
    // recall key timing: tap versus hold
    // --------------------
    logic rec_active_q, rec_sel_q, rec_supp_q, show_q;
    logic [31:0] hold_cnt_q;
    logic sel_level, rec_release, tap;

    assign sel_level = rec_sel_q ? keys.second_recall_key
                                 : keys.first_recall_key;
    assign rec_release = rec_active_q && !sel_level;
    assign tap = rec_release && !rec_supp_q; // [RULE6]
    assign sel_marker = rec_sel_q ? m2 : m1;
    assign sel_valid = rec_sel_q ? v2 : v1;

    // a press that came with the store key never locates
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rec_active_q <= 1'b0;
            rec_sel_q <= 1'b0;
            rec_supp_q <= 1'b0;
            show_q <= 1'b0;
            hold_cnt_q <= '0;
        end
        else if (!rec_active_q &&
                 (key_rise.first_recall_key || key_rise.second_recall_key))
        begin
            rec_active_q <= 1'b1;
            rec_sel_q <= key_rise.second_recall_key;
            rec_supp_q <= keys.store_key;
            hold_cnt_q <= '0;
        end
        else if (rec_release)
        begin
            rec_active_q <= 1'b0;
            show_q <= 1'b0;
        end
        else if (rec_active_q && hold_cnt_q == 32'(HOLD_CYCLES - 1))
        begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
            rec_supp_q <= 1'b1; // [RULE5]
            show_q <= state_q == tal_pkg::TAL_IDLE; // [RULE5]
        end
        else if (rec_active_q && hold_cnt_q < 32'(HOLD_CYCLES))
            hold_cnt_q <= hold_cnt_q + 1'b1;
    end

    // --------------------
    // markers
    // --------------------
    logic store_ok;
    assign store_ok = keys.store_key &&
                      state_q != tal_pkg::TAL_LOCATE && !looping; // [RULE3]

    tal_marker #(.CW(CW), .MOD(`TAL_CNT_MOD)) u_marker1 (
        .clk(pclk),
        .rst_n(presetn),
        .erase(erase_ev),
        .store(store_ok && key_rise.first_recall_key), // [RULE1]
        .adjust(clear_ev), // [RULE4]
        .value(counter_q),
        .offset(counter_q),
        .marker_q(m1),
        .valid_q(v1)
    );

    tal_marker #(.CW(CW), .MOD(`TAL_CNT_MOD)) u_marker2 (
        .clk(pclk),
        .rst_n(presetn),
        .erase(erase_ev),
        .store(store_ok && key_rise.second_recall_key), // [RULE1]
        .adjust(clear_ev), // [RULE4]
        .value(counter_q),
        .offset(counter_q),
        .marker_q(m2),
        .valid_q(v2)
    );

    // --------------------
    // locate and loop decisions
    // --------------------
    logic loc_ok, loc_bad, loop_req, loop_ok, loop_bad, at_target;
    logic [CW-1:0] lo_d, hi_d;

    assign loc_ok = tap && sel_valid && state_q != tal_pkg::TAL_REC &&
                    absdiff(counter_q, sel_marker) >= MIN_GAP; // [RULE10]
    assign loc_bad = tap && !loc_ok;
    assign loop_req = key_rise.loop_key && state_q != tal_pkg::TAL_REC;
    assign loop_ok = loop_req && v1 && v2 &&
                     absdiff(m1, m2) >= MIN_GAP; // [RULE19]
    assign loop_bad = loop_req && !loop_ok;
    assign lo_d = (m1 < m2) ? m1 : m2; // [RULE12]
    assign hi_d = (m1 < m2) ? m2 : m1; // [RULE12]
    assign at_target = counter_q == target_q;

    // --------------------
    // transport state machine
    // --------------------
    // a clear during the home wind wins over arrival and keys
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= tal_pkg::TAL_IDLE;
        else if (clear_ev && state_q == tal_pkg::TAL_WIND_HOME)
            state_q <= tal_pkg::TAL_IDLE; // [RULE9]
        else if (key_rise.stop_key)
            state_q <= tal_pkg::TAL_IDLE; // [RULE16]
        else if (key_rise.return_home_key &&
                 state_q != tal_pkg::TAL_REC)
            state_q <= (counter_q == '0) ? tal_pkg::TAL_IDLE
                                         : tal_pkg::TAL_WIND_HOME; // [RULE8]
        else if (loc_ok)
            state_q <= tal_pkg::TAL_LOCATE; // [RULE6]
        else if (loop_ok)
            state_q <= (counter_q == lo_d) ? tal_pkg::TAL_LOOP_PLAY
                                           : tal_pkg::TAL_LOOP_SEEK;
        else
        begin
            case (state_q)
                tal_pkg::TAL_IDLE:
                    if (key_rise.play_key && keys.record_key && |armed)
                        state_q <= tal_pkg::TAL_REC; // [RULE15]
                    else if (key_rise.play_key)
                        state_q <= tal_pkg::TAL_PLAY;
                tal_pkg::TAL_WIND_HOME, tal_pkg::TAL_LOCATE:
                    if (at_target)
                        state_q <= (play_pend_q || key_rise.play_key)
                                   ? tal_pkg::TAL_PLAY
                                   : tal_pkg::TAL_IDLE; // [RULE8] [RULE11]
                tal_pkg::TAL_LOOP_SEEK, tal_pkg::TAL_LOOP_REW:
                    if (at_target)
                        state_q <= tal_pkg::TAL_LOOP_PLAY; // [RULE13]
                tal_pkg::TAL_LOOP_PLAY:
                    if (counter_q == loop_hi_q)
                        state_q <= tal_pkg::TAL_LOOP_REW; // [RULE14]
                default:
                    ;
            endcase
        end
    end

    // wind target and loop bounds
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            target_q <= '0;
            loop_lo_q <= '0;
            loop_hi_q <= '0;
        end
        else if (key_rise.return_home_key)
            target_q <= '0;
        else if (loc_ok)
            target_q <= sel_marker;
        else if (loop_ok)
        begin
            target_q <= lo_d; // [RULE13]
            loop_lo_q <= lo_d;
            loop_hi_q <= hi_d;
        end
        else if (clear_ev && looping)
        begin
            target_q <= '0;
            loop_lo_q <= '0;
            loop_hi_q <= '0;
        end
        else if (state_q == tal_pkg::TAL_LOOP_PLAY)
            target_q <= loop_lo_q; // [RULE14]
    end

    // play pressed during a home or locate wind is remembered until arrival
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            play_pend_q <= 1'b0;
        else if (key_rise.play_key &&
                 (state_q == tal_pkg::TAL_WIND_HOME ||
                  state_q == tal_pkg::TAL_LOCATE))
            play_pend_q <= 1'b1; // [RULE11]
        else if (state_q != tal_pkg::TAL_WIND_HOME &&
                 state_q != tal_pkg::TAL_LOCATE)
            play_pend_q <= 1'b0;
    end

    // --------------------
    // lamp timing
    // --------------------
    logic [31:0] blink_cnt_q, flash_cnt_q;
    logic blink_q;
    logic [1:0] flash_q;

    // free-running blink shared by the marker and track arm lamps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else if (blink_cnt_q == 32'(BLINK_CYCLES - 1))
        begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 1'b1;
    end

    // refused locate or loop flashes for a fixed time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_q <= 2'b00;
            flash_cnt_q <= '0;
        end
        else if (loop_bad)
        begin
            flash_q <= 2'b11; // [RULE19]
            flash_cnt_q <= '0;
        end
        else if (loc_bad)
        begin
            flash_q <= rec_sel_q ? 2'b10 : 2'b01; // [RULE10]
            flash_cnt_q <= '0;
        end
        else if (flash_cnt_q == 32'(FLASH_CYCLES - 1))
            flash_q <= 2'b00;
        else if (|flash_q)
            flash_cnt_q <= flash_cnt_q + 1'b1;
    end

    // --------------------
    // registered outputs
    // --------------------
    // motor commands lag the state by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            motor <= '0;
        else
        begin
            motor.fast_forward <= winding && counter_q < target_q; // [RULE20]
            motor.rewind <= winding && counter_q > target_q; // [RULE20]
            motor.play <= state_q == tal_pkg::TAL_PLAY ||
                          state_q == tal_pkg::TAL_REC ||
                          state_q == tal_pkg::TAL_LOOP_PLAY;
            motor.record <= state_q == tal_pkg::TAL_REC; // [RULE15]
        end
    end

    // display and lamps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            display_value <= '0;
            marker_lamp <= 2'b00;
            loop_lamp <= 1'b0;
            track_arm_lamp <= '0;
        end
        else
        begin
            display_value <= show_q ? sel_marker : counter_q; // [RULE5]
            marker_lamp[0] <= flash_q[0] ? blink_q : v1; // [RULE1]
            marker_lamp[1] <= flash_q[1] ? blink_q : v2; // [RULE1]
            loop_lamp <= looping; // [RULE19]
            track_arm_lamp <= armed & {TRACKS{blink_q ||
                state_q == tal_pkg::TAL_REC}}; // [RULE15] [RULE16] [RULE17]
        end
    end

    // --------------------
    // apb slave, one wait state
    // --------------------
    logic access, done, mapped;
    logic [31:0] rd_d;

    assign access = psel && penable;
    assign done = access && pready;

    // read mux; unmapped reads return zero
    always_comb
    begin
        rd_d = '0;
        mapped = 1'b1;
        case (paddr)
            `TAL_CTRL_OFS:
                rd_d[`TAL_CTRL_LOCK_BIT] = lock_q;
            `TAL_STATUS_OFS:
            begin
                rd_d[3:0] = state_q;
                rd_d[`TAL_STAT_PEND_BIT] = play_pend_q;
                rd_d[`TAL_STAT_V1_BIT] = v1;
                rd_d[`TAL_STAT_V2_BIT] = v2;
                rd_d[`TAL_STAT_REC_BIT] = state_q == tal_pkg::TAL_REC;
            end
            `TAL_COUNTER_OFS:
                rd_d[CW-1:0] = counter_q;
            `TAL_MARKER1_OFS:
                rd_d[CW-1:0] = m1;
            `TAL_MARKER2_OFS:
                rd_d[CW-1:0] = m2;
            default:
                mapped = 1'b0;
        endcase
    end

    // answer registered one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access && !pready;
            prdata <= (access && !pready && !pwrite) ? rd_d : '0;
            pslverr <= access && !pready && !mapped;
        end
    end

    // control writes land at the completing edge only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_q <= `TAL_CTRL_RESET;
            erase_q <= 1'b0;
        end
        else
        begin
            erase_q <= done && pwrite && paddr == `TAL_CTRL_OFS &&
                       pwdata[`TAL_CTRL_ERASE_BIT];
            if (done && pwrite && paddr == `TAL_CTRL_OFS)
                lock_q <= pwdata[`TAL_CTRL_LOCK_BIT];
        end
    end

endmodule : tal_top

// ---- test/tal_deck.sv ----
// transport model: motor commands in, tach steps out
`timescale 1ns/1ps
module tal_deck (
    // clock, motors and tach
    input wire logic pclk,
    input wire tal_pkg::tal_motor_s motor,
    output logic tach_pulse,
    output logic tach_dir
);
    logic [2:0] ph_q = 3'h0;
    logic mov, dir_q;
    assign mov = motor.fast_forward | motor.rewind | motor.play;
    // one step per 8 clocks while moving; tach stands still when stopped
    always_ff @(posedge pclk)
        if (mov)
            ph_q <= ph_q + 3'h1;
    // direction never moves on a counted edge, so both sides agree
    always_ff @(posedge pclk)
        if (!(mov && ph_q == 3'h3))
            dir_q <= ~motor.rewind;
    assign tach_pulse = ph_q[2];
    assign tach_dir = dir_q;
endmodule : tal_deck

// ---- test/tal_monitor.sv ----
// concurrent checks on the autolocator top ports
`timescale 1ns/1ps
module tal_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // watched ports
    input wire tal_pkg::tal_keys_s panel_keys,
    input wire logic cassette_present,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tal_pkg::tal_motor_s motor,
    input wire logic [1:0] marker_lamp,
    input wire logic loop_lamp
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_one: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_wind_excl: assert property (
        !(motor.fast_forward && motor.rewind))
        else $error("both wind motors");
    a_rec_still: assert property (motor.record |-> !motor.rewind)
        else $error("record while winding");
    a_loop_norec: assert property (loop_lamp |-> !motor.record)
        else $error("loop in record");
    a_stop_wins: assert property (
        panel_keys.stop_key [*5] |-> motor == 4'h0)
        else $error("motor on with stop held");
    a_erase_lamps: assert property ($fell(cassette_present)
        |-> ##[1:6] marker_lamp == 2'b00) else $error("markers kept");
    // main scenarios reached
    c_record: cover property (motor.record);
    c_loop_rew: cover property (loop_lamp && motor.rewind);
    c_err: cover property (pslverr);
endmodule : tal_monitor

bind tal_top tal_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .panel_keys(panel_keys), .cassette_present(cassette_present),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor(motor),
    .marker_lamp(marker_lamp), .loop_lamp(loop_lamp));

// ---- test/testbench.sv ----
// self-checking bench for the tape autolocator
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cas = 1'b1, pready, pslverr, er, ll, tp, td;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] src = 4'h0, al;
    logic [13:0] dv, pos = 14'h0;
    logic [1:0] ml;
    tal_pkg::tal_keys_s k = '0;
    tal_pkg::tal_motor_s mo;
    int fail_count = 0, n_compared = 0, e1;
    logic [8:0] rows [6] = '{9'h000, 9'h004, 9'h008, 9'h00c, 9'h010, 9'h120};
    always #12.5 pclk = ~pclk;
    // own tally of tach steps gives the expected counter
    always @(posedge tp) pos <= td ? pos + 14'h1 : pos - 14'h1;
    tal_top #(.HOLD_CYCLES(20), .BLINK_CYCLES(4), .FLASH_CYCLES(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .panel_keys(k),
        .cassette_present(cas), .tach_pulse(tp), .tach_dir(td),
        .track_source_live(src), .motor(mo), .display_value(dv),
        .marker_lamp(ml), .loop_lamp(ll), .track_arm_lamp(al));
    tal_deck deck (.pclk(pclk), .motor(mo), .tach_pulse(tp), .tach_dir(td));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits on pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // short tap, well under the hold time
    task automatic key(input logic [8:0] v);
        @(posedge pclk);
        k <= v;
        repeat (6) @(posedge pclk);
        k <= '0;
        repeat (8) @(posedge pclk);
    endtask : key
    // polls state; only the watchdog ends a hang here
    task automatic wst(input logic [3:0] s);
        do
            apb(1'b0, 8'h04, 32'h0);
        while (rd[3:0] !== s);
    endtask : wst
    // play a while, stop, then store with the given recall key
    task automatic go(input int c, input logic [8:0] v);
        key(9'h008);
        repeat (c) @(posedge pclk);
        key(9'h004);
        k <= 9'h100;
        key(v);
    endtask : go
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i][7:0], 32'h0);
            chk({rd[30:0], er}, {31'h0, rows[i][8]});
        end
        apb(1'b1, 8'h00, 32'h0);
        go(160, 9'h180);
        e1 = pos;
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, e1);
        go(80, 9'h140);
        go(160, 9'h140);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, pos);
        k <= 9'h080;
        repeat (30) @(posedge pclk);
        chk({dv, mo}, {14'(e1), 4'h0});
        k <= '0;
        key(9'h080);
        wst(4'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, e1);
        key(9'h080);
        chk(mo, 4'h0);
        er = 1'b1;
        repeat (5) @(posedge pclk) er &= ml[0];
        chk(er, 1'b0);
        key(9'h001);
        wst(4'h7);
        chk(mo, 4'h4);
        wst(4'h6);
        chk(mo, 4'h2);
        key(9'h004);
        e1 = (e1 + 10000 - pos) % 10000;
        key(9'h010);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, e1);
        src <= 4'h5;
        k <= 9'h002;
        key(9'h00a);
        chk({al, mo}, 8'h53);
        key(9'h004);
        src <= 4'h0;
        repeat (8) @(posedge pclk);
        chk({al, mo}, 8'h00);
        cas <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(ml, 2'h0);
        key(9'h020);
        wst(4'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
